//--- core/cic_core_interrupt_control.sv
// interrupt control register with enables, flags and the request to the core
// assumes apb master on pclk; pin inputs are asynchronous, timer0_wrap and
// periph_irq come from logic on pclk
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cic_core_interrupt_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire cic_pkg::cic_src_s src,
    input wire logic periph_irq,
    output logic core_irq_req,
    output logic irq
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    // pin side: bit 0 external pin, bits 4:1 upper port pins
    logic [4:0] pin_raw;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] last;
    logic [3:0] pin_toggle;
    logic ext_event;
    logic port_event;

    // bus side
    logic acc;
    logic setup_rd;
    logic sel_ctrl;
    logic sel_stat;
    logic sel_mask;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;

    // interrupt_control: enables 7:3, flags 2:0
    logic [4:0] en_q;
    logic [2:0] flag_q;
    logic [2:0] flag_set;
    logic [7:0] ctrl;

    // request terms
    logic [2:0] src_term;
    logic periph_term;
    logic next_req;

    // status and mask
    logic [3:0] events;
    logic [3:0] stat_clr;
    logic [3:0] stat;
    logic [3:0] mask;

    // read path
    logic [31:0] next_rdata;

    // ----------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------
    assign pin_raw = {src.upper_port_pins, src.ext_edge};

    // two flops per pin before any logic reads it
    for (genvar i = 0; i < 5; i++) begin : g_pin
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                sync1[i] <= 1'b0;
                sync2[i] <= 1'b0;
                last[i] <= 1'b0;
            end else if (clk_en) begin
                sync1[i] <= pin_raw[i];
                sync2[i] <= sync1[i];
                last[i] <= sync2[i];
            end
        end
    end

    // idle pins reset low, so no false edge after reset
    assign ext_event = sync2[0] && !last[0];
    assign pin_toggle = sync2[4:1] ^ last[4:1];
    assign port_event = |pin_toggle;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    // zero wait states: each access ends in its first access cycle
    assign acc = psel && penable;
    assign setup_rd = psel && !penable && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        sel_ctrl = 1'b0;
        sel_stat = 1'b0;
        sel_mask = 1'b0;
        if (paddr == cic_pkg::CTRL_OFFSET) begin
            sel_ctrl = 1'b1;
        end else if (paddr == cic_pkg::STAT_OFFSET) begin
            sel_stat = 1'b1;
        end else if (paddr == cic_pkg::MASK_OFFSET) begin
            sel_mask = 1'b1;
        end
    end

    // unmapped address: error, nothing written
    assign pslverr = acc && !(sel_ctrl || sel_stat || sel_mask);

    assign wr_ctrl = acc && pwrite && pready && sel_ctrl;
    assign wr_stat = acc && pwrite && pready && sel_stat;
    assign wr_mask = acc && pwrite && pready && sel_mask;

    // ----------------------------------------
    // interrupt_control: enable bits
    // ----------------------------------------
    // global, peripheral-group and three source enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= cic_pkg::CTRL_RESET[7:3];
        end else if (clk_en && wr_ctrl) begin
            en_q <= pwdata[7:3];
        end
    end

    // ----------------------------------------
    // interrupt_control: sticky source flags
    // ----------------------------------------
    // bit 2 timer0 wrap, bit 1 external pin, bit 0 port change
    assign flag_set = {src.timer0_wrap, ext_event, port_event};

    // event beats a same-cycle software write, so none is lost
    for (genvar f = 0; f < 3; f++) begin : g_flag
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                flag_q[f] <= cic_pkg::CTRL_RESET[f];
            end else if (clk_en) begin
                if (flag_set[f]) begin
                    flag_q[f] <= 1'b1;
                end else if (wr_ctrl) begin
                    flag_q[f] <= pwdata[f];
                end
            end
        end
    end

    assign ctrl = {en_q, flag_q};

    // ----------------------------------------
    // request to the core
    // ----------------------------------------
    // a source counts only while its own enable is set
    assign src_term = en_q[2:0] & flag_q;

    // peripheral requests need the group enable
    assign periph_term = en_q[3] && periph_irq;

    // en_q[4] is the global enable
    always_comb begin
        next_req = en_q[4] && ((|src_term) || periph_term);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_irq_req <= 1'b0;
        end else if (clk_en) begin
            core_irq_req <= next_req;
        end
    end

    // ----------------------------------------
    // sticky event status
    // ----------------------------------------
    // bit 0 timer0, bit 1 ext pin, bit 2 port change, bit 3 peripheral
    assign events = {periph_irq, port_event, ext_event, src.timer0_wrap};

    // write one to clear
    assign stat_clr = wr_stat ? pwdata[3:0] : 4'h0;

    // set wins over a clear in the same cycle
    for (genvar s = 0; s < 4; s++) begin : g_stat
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stat[s] <= cic_pkg::STAT_RESET[s];
            end else if (clk_en) begin
                if (events[s]) begin
                    stat[s] <= 1'b1;
                end else if (stat_clr[s]) begin
                    stat[s] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // mask and interrupt line
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= cic_pkg::MASK_RESET;
        end else if (clk_en && wr_mask) begin
            mask <= pwdata[3:0];
        end
    end

    // level, high while any unmasked status bit is set
    assign irq = |(stat & mask);

    // ----------------------------------------
    // read data
    // ----------------------------------------
    // unmapped reads return zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (sel_ctrl) begin
            next_rdata = {24'h000000, ctrl};
        end else if (sel_stat) begin
            next_rdata = {28'h0000000, stat};
        end else if (sel_mask) begin
            next_rdata = {28'h0000000, mask};
        end
    end

    // captured in the setup cycle, held until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && setup_rd) begin
            prdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

//--- core/cic_pkg.sv
// package for the interrupt control block: offsets, bit positions, reset values
// assumes an apb slave with 32-bit data and one register per aligned word
package cic_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STAT_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    // ----------------------------------------
    // interrupt_control bit positions
    // ----------------------------------------
    localparam int GIE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int T0IE_BIT = 5;
    localparam int EXIE_BIT = 4;
    localparam int PCIE_BIT = 3;
    localparam int T0F_BIT = 2;
    localparam int EXF_BIT = 1;
    localparam int PCF_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // ----------------------------------------
    // event status / mask layout
    // ----------------------------------------
    localparam int EV_T0 = 0;
    localparam int EV_EX = 1;
    localparam int EV_PC = 2;
    localparam int EV_PERIPH = 3;
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;

    typedef struct packed {
        logic timer0_wrap;
        logic ext_edge;
        logic [3:0] upper_port_pins;
    } cic_src_s;
endpackage

//--- verification/cic_chk_sva.sv
// checker for the interrupt control block, bound to its top module
// assumes one clock domain and a zero-wait apb slave
`timescale 1ns/10ps
`default_nettype none
module cic_chk_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic periph_irq,
    input wire logic core_irq_req
);
    logic [1:0] ctl_q;
    wire logic acc = psel && penable;
    wire logic map = paddr inside {8'h00, 8'h04, 8'h08};
    // shadow of global and peripheral-group enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctl_q <= 2'b00;
        else if (acc && clk_en && pwrite && paddr == 8'h00) ctl_q <= pwdata[7:6];
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_gie_blocks: assert property (!ctl_q[1] |=> !core_irq_req)
        else $error("request without global enable");
    a_periph_pass: assert property (clk_en && ctl_q == 2'b11 && periph_irq |=> core_irq_req)
        else $error("peripheral request not passed");
    a_ready_zero: assert property (acc |-> pready) else $error("wait state seen");
    a_unmapped_err: assert property (acc && !map |-> pslverr) else $error("no error flag");
    a_mapped_ok: assert property (acc && map |-> !pslverr) else $error("false error flag");
    a_err_access_only: assert property (!acc |-> !pslverr) else $error("error out of access");
    a_unmapped_zero: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule
bind cic_core_interrupt_control cic_chk_sva chk_u (.pclk, .presetn, .clk_en, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .periph_irq, .core_irq_req);
`default_nettype wire

//--- verification/cic_src_model.sv
// source model: timer0 pulse, pin levels and peripheral request on pclk
// assumes the bench drives its inputs just after rising edges
`timescale 1ns/10ps
`default_nettype none
module cic_src_model (
    input wire logic pclk,
    input wire logic kick,
    input wire logic ext_lvl,
    input wire logic [3:0] pins,
    input wire logic per,
    output var cic_pkg::cic_src_s src,
    output var logic periph_irq
);
    always_ff @(posedge pclk) begin
        src.timer0_wrap <= kick;
        src.ext_edge <= ext_lvl;
        src.upper_port_pins <= pins;
        periph_irq <= per;
    end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// bench: apb driver, event stimulus and reference model of the interrupt block
// assumes the source model and checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
    logic kick = 0, ext = 0, per = 0, irq, req, periph_irq;
    logic [3:0] pins = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q, r = 32'h48cf;
    int n_mismatch = 0, n_checks = 0, m_ctl = 0, m_stat = 0;
    cic_pkg::cic_src_s src;
    always #20 pclk = ~pclk;
    cic_src_model src_u (.pclk, .kick, .ext_lvl(ext), .pins, .per, .src, .periph_irq);
    cic_core_interrupt_control dut_u (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .src, .periph_irq, .core_irq_req(req), .irq);
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task automatic ck(string n, logic [31:0] e, logic [31:0] v);
        n_checks++;
        if (v !== e) begin
            $display("wrong value %s exp %h got %h", n, e, v);
            n_mismatch++;
        end
    endtask
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (!pready) @(posedge pclk);
        q = prdata;
        se = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rd(logic [7:0] a, int e);
        bus(0, a, 0);
        ck("prdata", e, q);
    endtask
    task automatic wc(int v);
        bus(1, 8'h00, v);
        m_ctl = v;
    endtask
    task automatic rq();
        repeat (3) @(posedge pclk);
        ck("core_irq_req", m_ctl[7] && (|(m_ctl[5:3] & m_ctl[2:0]) || m_ctl[6] && per), req);
    endtask
    task automatic ev(int k);
        r = xs(r);
        kick <= (k == 0);
        ext <= (k == 1);
        if (k == 2) pins <= pins ^ (r[3:0] | 4'h1);
        @(posedge pclk);
        kick <= 0;
        repeat (5) @(posedge pclk);
        ext <= 0;
        m_ctl |= 4 >> k;
        m_stat |= 1 << k;
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        rd(8'h00, 0);
        rd(8'h08, 0);
        bus(0, 8'h0c, 32'h0);
        ck("pslverr", 1, se);
        for (int k = 0; k < 3; k++) begin
            ev(k);
            rq();
            rd(8'h00, m_ctl);
            wc(m_ctl | 'h80 | (32 >> k));
            rq();
            wc('h80 | (32 >> k));
            rq();
        end
        rd(8'h04, m_stat);
        bus(1, 8'h08, 32'h2);
        ck("irq", 1, irq);
        bus(1, 8'h04, 32'h2);
        ck("irq", 0, irq);
        rd(8'h04, 5);
        per <= 1;
        wc('h40);
        rq();
        wc('h80);
        rq();
        wc('hc0);
        rq();
        give_verdict();
    end
endmodule
`default_nettype wire
